/* File: inc/pmc_map.svh */
// Command codes, field positions, reset values and timing of the control block
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_CMD_CLEAR_FAULTS 8'h03
`define PMC_CMD_BUS_STATUS 8'hD7
`define PMC_CMD_TAKEOVER 8'hD8
`define PMC_CMD_EE_LOW 8'hD9
`define PMC_CMD_EE_HIGH 8'hF4
`define PMC_CMD_TEST 8'hDF
`define PMC_CMD_ALARM 8'hEA
`define PMC_CMD_STATE2 8'hEB
`define PMC_SB_HAS 0
`define PMC_SB_REQ 1
`define PMC_SB_ALERT 2
`define PMC_SB_ERR 3
`define PMC_SB_NIBBLE 4
`define PMC_BUS_STATUS_RST 8'h01
`define PMC_TF_STRETCH 7
`define PMC_TF_ORING 4
`define PMC_TF_SERVICE 1
`define PMC_TF_LED_TEST 0
`define PMC_TF_MASK 8'h93
`define PMC_TF_RST 8'h00
`define PMC_ST2_RESTARTED 0
`define PMC_EE_HALF 32
`define PMC_CLK_NS 100
`define PMC_MS_NS 1000000
`define PMC_LED_ON_MS 7000
`define PMC_LED_OFF_MS 2000
`define PMC_FLASH_MS 500
`define PMC_CC_HOLD_MS 20000
`define PMC_OV_DELAY_MS 1000
`define PMC_OV_WINDOW_MS 60000
`define PMC_OV_TRIES 3
`endif

/* File: inc/pmc_pkg.sv */
// Types shared by the dual-master control block
package pmc_pkg;
	typedef struct packed {
		logic rd;
		logic [7:0] code;
		logic [5:0] idx;
		logic [7:0] data;
		logic last;
		logic pec_ok;
	} pmc_frame_t;
	typedef struct packed {
		logic [7:0] fault;
		logic settled;
		logic unit_on;
		logic in_ok;
		logic in_limit;
		logic vout_hi;
		logic pwr_up;
		logic overload;
		logic ov_trip;
		logic restart_ok;
	} pmc_plant_t;
	typedef enum logic [1:0] {PMC_LT_IDLE, PMC_LT_ON, PMC_LT_DARK} pmc_ledt_t;
	typedef enum logic [1:0] {PMC_OV_IDLE, PMC_OV_WAIT, PMC_OV_LATCH} pmc_ov_t;
endpackage

/* File: logic/pmc_ctrl.sv */
// Dual-master command control, LEDs, restart and fault freezing
`timescale 1ns/1ps
`include "pmc_map.svh"
// Behaviour
// RL1: Ownership status byte is readable by either master at any time.
// RL2: Status nibbles: error, alert, requested, has control; bus 0 owns at reset.
// RL3: Master without control may only issue takeover and clear faults.
// RL4: Takeover moves command control to the requesting master.
// RL5: Handover waits until the owner has finished its write with stop.
// RL6: Reads by the losing master do not hold back a handover.
// RL7: Takeover acts only after a valid trailing check byte.
// RL8: After a handover both alert lines are asserted.
// RL9: Each master clears its own alert with clear faults.
// RL10: Only the owner's clear faults wipes the rectifier alarm registers.
// RL11: 64 user bytes, low half and high half by two command codes.
// RL12: Block write and block read framing, read count at most 32.
// RL13: Test byte: stretch, oring test, service LED, LED test; rest reserved.
// RL14: LED test lights all four LEDs 7 s on, 2 s off; off when cleared.
// RL15: Service LED flashes 0.5 s on and off while its bit is set.
// RL16: Host waits about 30 s after an oring test, one unit at a time.
// RL17: At power up overload is held in constant current for up to 20 s.
// RL18: Output LED blinks in limit above 36 V, steady on, off when off.
// RL19: Restart actions keep the unit off at least 2 s.
// RL20: A good restart clears alarms and sets the restarted flag.
// RL21: Overvoltage: three 1 s delayed retries per minute window, then latch.
// RL22: Alarms freeze only once settled, raise alert, hold until cleared.
// RL23: Fault flags are sticky and reassert while the fault persists.
// RL24: Each bus drives its own open-drain active-low alert pin.
module pmc_ctrl import pmc_pkg::*; #(
	parameter int unsigned TICK_CYCLES = `PMC_MS_NS / `PMC_CLK_NS
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic lk_clk,
	input wire logic lk_srst,
	input wire logic [1:0] lk_req_valid,
	input wire pmc_frame_t [1:0] lk_req,
	output logic [1:0] lk_ready,
	output logic [1:0] lk_rsp_valid,
	output logic [1:0][7:0] lk_rsp_data,
	output logic [1:0] alert_o,
	output logic [1:0] alert_oe_n,
	input wire pmc_plant_t plant,
	output logic led_input,
	output logic led_output,
	output logic led_fault,
	output logic led_service,
	output logic stretch_en,
	output logic oring_test,
	output logic cc_hold,
	output logic ov_restart,
	output logic ov_latched
);
	// ****************************************
	// Link side: one handshake per frame
	// ****************************************
	pmc_frame_t lk_hold [2];
	logic [1:0] lk_busy;
	logic [1:0] lk_req_tog;
	logic [1:0] lk_ack_s1;
	logic [1:0] lk_ack_s2;
	logic [1:0] lk_ack_last;
	logic [1:0] ack_tog;
	logic [7:0] rsp [2];

	assign lk_ready = ~lk_busy;

	genvar gb;
	generate
		for (gb = 0; gb < 2; gb++) begin : g_lk
			always_ff @(posedge lk_clk) begin
				if (lk_srst) begin
					lk_hold[gb] <= '0;
					lk_busy[gb] <= 1'b0;
					lk_req_tog[gb] <= 1'b0;
					lk_ack_s1[gb] <= 1'b0;
					lk_ack_s2[gb] <= 1'b0;
					lk_ack_last[gb] <= 1'b0;
					lk_rsp_valid[gb] <= 1'b0;
					lk_rsp_data[gb] <= 8'h00;
				end else begin
					lk_ack_s1[gb] <= ack_tog[gb];
					lk_ack_s2[gb] <= lk_ack_s1[gb];
					lk_ack_last[gb] <= lk_ack_s2[gb];
					lk_rsp_valid[gb] <= 1'b0;
					if (lk_busy[gb] && (lk_ack_s2[gb] ^ lk_ack_last[gb])) begin
						lk_busy[gb] <= 1'b0;
						lk_rsp_valid[gb] <= 1'b1;
						lk_rsp_data[gb] <= rsp[gb];
					end else if (lk_req_valid[gb] && !lk_busy[gb]) begin
						lk_hold[gb] <= lk_req[gb];
						lk_busy[gb] <= 1'b1;
						lk_req_tog[gb] <= ~lk_req_tog[gb];
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Crossing into the controller clock
	// ****************************************
	logic [1:0] req_s1;
	logic [1:0] req_s2;
	logic [1:0] req_last;
	logic [1:0] ev;
	pmc_plant_t pl_s1;
	pmc_plant_t pl;
	pmc_plant_t pl_d;

	// Frame words stay still until the ack returns, so no per-bit sync
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			req_s1 <= 2'b00;
			req_s2 <= 2'b00;
			req_last <= 2'b00;
			pl_s1 <= '0;
			pl <= '0;
			pl_d <= '0;
		end else begin
			req_s1 <= lk_req_tog;
			req_s2 <= req_s1;
			req_last <= req_s2;
			pl_s1 <= plant;
			pl <= pl_s1;
			pl_d <= pl;
		end
	end
	assign ev = req_s2 ^ req_last;

	// ****************************************
	// Ownership, takeover and alerts
	// ****************************************
	logic owner;
	logic [1:0] req_ctl;
	logic [1:0] cmd_err;
	logic [1:0] busy_wr;
	logic [1:0] alert;
	logic [1:0] clr_cmd;
	logic [1:0] own_commit;
	logic do_hand;
	logic fault_alert;
	logic [7:0] alarm;
	logic restarted;
	logic [7:0] bus_status;

	always_comb begin
		clr_cmd = 2'b00;
		own_commit = 2'b00;
		for (int b = 0; b < 2; b++) begin
			clr_cmd[b] = ev[b] && !lk_hold[b].rd && lk_hold[b].last &&
				lk_hold[b].pec_ok &&
				lk_hold[b].code == `PMC_CMD_CLEAR_FAULTS;
			own_commit[b] = ev[b] && !lk_hold[b].rd && lk_hold[b].last &&
				lk_hold[b].pec_ok && owner == 1'(b);
		end
	end

	// Only open writes of the owner block a handover; reads never do
	assign do_hand = req_ctl[~owner] && !busy_wr[owner]; // RL5 RL6
	assign fault_alert = pl.settled && |(pl.fault & ~alarm); // RL22

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			owner <= 1'b0; // RL2
			req_ctl <= 2'b00;
			cmd_err <= 2'b00;
			busy_wr <= 2'b00;
			alert <= 2'b00;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (ev[b] && !lk_hold[b].rd) begin
					if (!lk_hold[b].last)
						busy_wr[b] <= 1'b1;
					else begin
						busy_wr[b] <= 1'b0;
						if (!lk_hold[b].pec_ok)
							cmd_err[b] <= 1'b1; // RL7
						else if (lk_hold[b].code == `PMC_CMD_TAKEOVER) begin
							if (owner != 1'(b))
								req_ctl[b] <= 1'b1; // RL4 RL7
						end else if (clr_cmd[b]) begin
							alert[b] <= 1'b0; // RL9
							cmd_err[b] <= 1'b0;
						end else if (owner != 1'(b))
							cmd_err[b] <= 1'b1; // RL3
					end
				end
			end
			// Sets come last so a same-cycle clear cannot lose them
			if (do_hand) begin
				owner <= ~owner; // RL4
				req_ctl <= 2'b00;
				alert <= 2'b11; // RL8
			end
			if (fault_alert)
				alert <= 2'b11; // RL22
		end
	end

	always_comb begin
		bus_status = 8'h00;
		for (int b = 0; b < 2; b++) begin
			bus_status[`PMC_SB_NIBBLE * b + `PMC_SB_ERR] = cmd_err[b]; // RL2
			bus_status[`PMC_SB_NIBBLE * b + `PMC_SB_ALERT] = alert[b];
			bus_status[`PMC_SB_NIBBLE * b + `PMC_SB_REQ] = req_ctl[b];
			bus_status[`PMC_SB_NIBBLE * b + `PMC_SB_HAS] = owner == 1'(b);
		end
	end

	// Open drain: pull low while alerting, release otherwise
	assign alert_o = 2'b00; // RL24
	assign alert_oe_n = ~alert; // RL24

	// ****************************************
	// Alarm freezing and restart flag
	// ****************************************
	logic restart_rise;
	assign restart_rise = pl.restart_ok && !pl_d.restart_ok;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			alarm <= 8'h00;
			restarted <= 1'b0;
		end else begin
			if (|(clr_cmd & own_commit)) begin
				alarm <= 8'h00; // RL10
				restarted <= 1'b0;
			end
			if (restart_rise) begin
				alarm <= 8'h00; // RL20
				restarted <= 1'b1; // RL20
			end
			// Transient states are ignored until settled; faults re-latch
			if (fault_alert)
				alarm <= alarm | pl.fault; // RL22 RL23
		end
	end

	// ****************************************
	// Test byte and user storage
	// ****************************************
	logic [7:0] test_reg;
	logic [7:0] test_pend [2];
	logic [7:0] ee [64];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			test_reg <= `PMC_TF_RST;
			test_pend[0] <= 8'h00;
			test_pend[1] <= 8'h00;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (ev[b] && !lk_hold[b].rd && !lk_hold[b].last &&
					lk_hold[b].idx == 6'h00)
					test_pend[b] <= lk_hold[b].data;
				// Written only when the check byte is good and from the owner
				if (own_commit[b] && lk_hold[b].code == `PMC_CMD_TEST)
					test_reg <= test_pend[b] & `PMC_TF_MASK; // RL3 RL13
			end
		end
	end

	// Bytes land as they arrive; a later bad check byte does not undo them
	always_ff @(posedge ref_clk) begin
		for (int b = 0; b < 2; b++) begin
			if (ev[b] && !lk_hold[b].rd && !lk_hold[b].last &&
				owner == 1'(b) && lk_hold[b].idx != 6'h00 &&
				lk_hold[b].idx <= 6'(`PMC_EE_HALF) &&
				(lk_hold[b].code == `PMC_CMD_EE_LOW ||
				lk_hold[b].code == `PMC_CMD_EE_HIGH))
				ee[{lk_hold[b].code == `PMC_CMD_EE_HIGH,
					5'(lk_hold[b].idx - 6'h01)}] <= lk_hold[b].data; // RL11 RL12
		end
	end

	// ****************************************
	// Read answers
	// ****************************************
	logic [7:0] next_rsp [2];

	always_comb begin
		for (int b = 0; b < 2; b++) begin
			next_rsp[b] = 8'h00;
			if (lk_hold[b].code == `PMC_CMD_BUS_STATUS)
				next_rsp[b] = bus_status; // RL1
			else if (lk_hold[b].code == `PMC_CMD_TEST)
				next_rsp[b] = test_reg;
			else if (lk_hold[b].code == `PMC_CMD_ALARM)
				next_rsp[b] = alarm;
			else if (lk_hold[b].code == `PMC_CMD_STATE2)
				next_rsp[b] = 8'(restarted) << `PMC_ST2_RESTARTED;
			else if (lk_hold[b].code == `PMC_CMD_EE_LOW ||
				lk_hold[b].code == `PMC_CMD_EE_HIGH) begin
				if (lk_hold[b].idx == 6'h00)
					next_rsp[b] = 8'(`PMC_EE_HALF); // RL12
				else if (lk_hold[b].idx <= 6'(`PMC_EE_HALF))
					next_rsp[b] = ee[{lk_hold[b].code == `PMC_CMD_EE_HIGH,
						5'(lk_hold[b].idx - 6'h01)}]; // RL11
			end
			if (!lk_hold[b].rd)
				next_rsp[b] = 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ack_tog <= 2'b00;
			rsp[0] <= 8'h00;
			rsp[1] <= 8'h00;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (ev[b]) begin
					rsp[b] <= next_rsp[b];
					ack_tog[b] <= ~ack_tog[b];
				end
			end
		end
	end

	// ****************************************
	// Millisecond tick, LED test and flashing
	// ****************************************
	logic [15:0] tick_cnt;
	logic tick;
	logic [15:0] flash_cnt;
	logic flash_ph;
	pmc_ledt_t lt_st;
	logic [15:0] lt_cnt;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tick_cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			tick <= tick_cnt == 16'(TICK_CYCLES - 1);
			if (tick_cnt == 16'(TICK_CYCLES - 1))
				tick_cnt <= 16'h0000;
			else
				tick_cnt <= tick_cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flash_cnt <= 16'h0000;
			flash_ph <= 1'b0;
		end else if (tick) begin
			if (flash_cnt == 16'(`PMC_FLASH_MS - 1)) begin
				flash_cnt <= 16'h0000;
				flash_ph <= ~flash_ph; // RL15 RL18
			end else
				flash_cnt <= flash_cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lt_st <= PMC_LT_IDLE;
			lt_cnt <= 16'h0000;
		end else if (!test_reg[`PMC_TF_LED_TEST]) begin
			lt_st <= PMC_LT_IDLE; // RL14
			lt_cnt <= 16'h0000;
		end else begin
			case (lt_st)
				PMC_LT_IDLE: begin
					lt_st <= PMC_LT_ON;
					lt_cnt <= 16'h0000;
				end
				PMC_LT_ON: begin
					if (tick && lt_cnt == 16'(`PMC_LED_ON_MS - 1)) begin
						lt_st <= PMC_LT_DARK; // RL14
						lt_cnt <= 16'h0000;
					end else if (tick)
						lt_cnt <= lt_cnt + 16'h0001;
				end
				PMC_LT_DARK: begin
					if (tick && lt_cnt == 16'(`PMC_LED_OFF_MS - 1)) begin
						lt_st <= PMC_LT_ON; // RL14
						lt_cnt <= 16'h0000;
					end else if (tick)
						lt_cnt <= lt_cnt + 16'h0001;
				end
				default: lt_st <= PMC_LT_IDLE;
			endcase
		end
	end

	// ****************************************
	// Power-up hold and overvoltage retries
	// ****************************************
	logic [15:0] cc_cnt;
	logic cc_run;
	pmc_ov_t ov_st;
	logic [1:0] ov_tries;
	logic [15:0] ov_cnt;
	logic [15:0] win_cnt;
	logic win_run;
	logic ov_rise;
	assign ov_rise = pl.ov_trip && !pl_d.ov_trip;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cc_run <= 1'b0;
			cc_cnt <= 16'h0000;
		end else if (pl.pwr_up && !pl_d.pwr_up) begin
			cc_run <= 1'b1;
			cc_cnt <= 16'h0000;
		end else if (cc_run && tick) begin
			if (cc_cnt == 16'(`PMC_CC_HOLD_MS - 1))
				cc_run <= 1'b0; // RL17
			else
				cc_cnt <= cc_cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ov_st <= PMC_OV_IDLE;
			ov_tries <= 2'b00;
			ov_cnt <= 16'h0000;
			win_cnt <= 16'h0000;
			win_run <= 1'b0;
			ov_restart <= 1'b0;
		end else begin
			ov_restart <= 1'b0;
			if (win_run && tick) begin
				if (win_cnt == 16'(`PMC_OV_WINDOW_MS - 1)) begin
					win_run <= 1'b0; // RL21
					ov_tries <= 2'b00;
				end else
					win_cnt <= win_cnt + 16'h0001;
			end
			case (ov_st)
				PMC_OV_IDLE: begin
					if (ov_rise) begin
						if (ov_tries == 2'(`PMC_OV_TRIES))
							ov_st <= PMC_OV_LATCH; // RL21
						else begin
							ov_st <= PMC_OV_WAIT;
							ov_cnt <= 16'h0000;
						end
						if (!win_run) begin
							win_run <= 1'b1;
							win_cnt <= 16'h0000;
						end
					end
				end
				PMC_OV_WAIT: begin
					if (tick && ov_cnt == 16'(`PMC_OV_DELAY_MS - 1)) begin
						ov_st <= PMC_OV_IDLE;
						ov_restart <= 1'b1; // RL21
						ov_tries <= ov_tries + 2'b01;
					end else if (tick)
						ov_cnt <= ov_cnt + 16'h0001;
				end
				PMC_OV_LATCH: begin
					if (restart_rise) begin
						ov_st <= PMC_OV_IDLE;
						ov_tries <= 2'b00;
					end
				end
				default: ov_st <= PMC_OV_IDLE;
			endcase
		end
	end

	// ****************************************
	// Registered pin outputs
	// ****************************************
	logic lt_lit;
	logic out_norm;
	assign lt_lit = lt_st == PMC_LT_ON;
	assign out_norm = pl.unit_on && ov_st != PMC_OV_LATCH &&
		(!(pl.in_limit && pl.vout_hi) || flash_ph); // RL18

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			led_input <= 1'b0;
			led_output <= 1'b0;
			led_fault <= 1'b0;
			led_service <= 1'b0;
			stretch_en <= 1'b0;
			oring_test <= 1'b0;
			cc_hold <= 1'b0;
			ov_latched <= 1'b0;
		end else begin
			if (test_reg[`PMC_TF_LED_TEST]) begin
				led_input <= lt_lit; // RL14
				led_output <= lt_lit;
				led_fault <= lt_lit;
				led_service <= lt_lit;
			end else begin
				led_input <= pl.in_ok;
				led_output <= out_norm; // RL18
				led_fault <= |alarm;
				led_service <= test_reg[`PMC_TF_SERVICE] && flash_ph; // RL15
			end
			stretch_en <= test_reg[`PMC_TF_STRETCH]; // RL13
			oring_test <= test_reg[`PMC_TF_ORING]; // RL13
			cc_hold <= cc_run && pl.overload; // RL17
			ov_latched <= ov_st == PMC_OV_LATCH;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_hand_ready;
		req_ctl[~owner] && !busy_wr[owner];
	endsequence
	sequence s_lt_on_end;
		lt_st == PMC_LT_ON && tick && lt_cnt == 16'(`PMC_LED_ON_MS - 1) &&
			test_reg[`PMC_TF_LED_TEST];
	endsequence

	a_status_read: assert property ( // RL1
		ev[1] && lk_hold[1].rd && lk_hold[1].code == `PMC_CMD_BUS_STATUS
		|=> rsp[1] == $past(bus_status) && ack_tog[1] != $past(ack_tog[1]))
		else $error("status byte not returned");
	a_single_owner: assert property ( // RL2
		bus_status[`PMC_SB_NIBBLE + `PMC_SB_HAS] !=
		bus_status[`PMC_SB_HAS] && !req_ctl[owner])
		else $error("control held by none or both");
	a_nonowner_ignored: assert property ( // RL3
		ev[1] && owner == 1'b0 && lk_hold[1].code == `PMC_CMD_TEST
		&& !ev[0] |=> $stable(test_reg))
		else $error("non-owner changed test byte");
	a_handover_moves: assert property ( // RL4
		s_hand_ready |=> owner != $past(owner) && req_ctl == 2'b00)
		else $error("pending takeover not executed");
	a_hold_while_busy: assert property ( // RL5
		busy_wr[owner] |=> owner == $past(owner))
		else $error("control moved during owner write");
	a_pec_gate: assert property ( // RL7
		ev[1] && !lk_hold[1].rd && lk_hold[1].last && !lk_hold[1].pec_ok &&
		!req_ctl[1]
		|=> !req_ctl[1] && cmd_err[1])
		else $error("takeover acted on bad check byte");
	a_alert_both: assert property ( // RL8
		$changed(owner) |-> alert == 2'b11 ##1 alert_oe_n == 2'b00)
		else $error("handover did not alert both buses");
	a_ee_store: assert property ( // RL11
		ev[1] && owner == 1'b1 && !lk_hold[1].rd && !lk_hold[1].last &&
		lk_hold[1].code == `PMC_CMD_EE_HIGH && lk_hold[1].idx == 6'h01 &&
		!ev[0] |=> ee[32] == $past(lk_hold[1].data))
		else $error("upper storage byte not written");
	a_led_test_cycle: assert property ( // RL14
		s_lt_on_end |=> lt_st == PMC_LT_DARK ##1 !led_output)
		else $error("LED test on phase did not end");
	a_restart_clears: assert property ( // RL20
		restart_rise && !fault_alert |=> alarm == 8'h00 && restarted)
		else $error("restart did not clear alarms");
	a_ov_latch: assert property ( // RL21
		ov_st == PMC_OV_IDLE && ov_rise && ov_tries == 2'(`PMC_OV_TRIES)
		|=> ov_st == PMC_OV_LATCH ##1 ov_latched)
		else $error("fourth overvoltage did not latch");
	a_fault_sticky: assert property ( // RL23
		pl.settled && |(pl.fault & ~alarm) |=> (alarm & $past(pl.fault))
		== $past(pl.fault))
		else $error("settled fault not latched");
endmodule // pmc_ctrl

/* File: tb/pmc_mst.sv */
// Bus master model for one link port of the control block
`timescale 1ns/1ps
module pmc_mst import pmc_pkg::*; (
	input wire logic lk_clk,
	output logic req_valid,
	output pmc_frame_t req,
	input wire logic ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data
);
	// ****
	// Frame handshake
	// ****
	initial begin
		req_valid = 1'b0;
		req = '0;
	end
	// Released fields show the inverse so stale data cannot pass as valid
	task automatic xfer(input pmc_frame_t f, output logic [7:0] d);
		int n;
		n = 0;
		d = 8'hxx;
		@(negedge lk_clk);
		req <= f;
		req_valid <= 1'b1;
		@(posedge lk_clk);
		while (ready !== 1'b1 && n < 50) begin
			@(posedge lk_clk);
			n++;
		end
		@(negedge lk_clk);
		req_valid <= 1'b0;
		req <= ~f;
		for (n = 0; n < 50 && rsp_valid !== 1'b1; n++)
			@(posedge lk_clk);
		if (rsp_valid === 1'b1)
			d = rsp_data;
	endtask
endmodule // pmc_mst

/* File: tb/test_dual_master_pmbus_control.sv */
// Self-checking bench for the dual-master control block
`timescale 1ns/1ps
`include "pmc_map.svh"
module test_dual_master_pmbus_control import pmc_pkg::*; ;
	// ****
	// Signals and clocks
	// ****
	logic ref_clk = 1'b0;
	logic lk_clk = 1'b0;
	logic srst = 1'b1;
	logic lk_srst = 1'b1;
	logic [1:0] req_v, rdy, rv, al_o, al_oe_n;
	pmc_frame_t [1:0] req;
	logic [1:0][7:0] rsp;
	pmc_plant_t plant = '0;
	logic led_i, led_o, led_f, led_s, str, orng, cch, ovr, ovl;
	logic [1:0] alert_n;
	int error_cnt = 0;
	int total_checks = 0;
	// Pull-up on each open-drain alert line
	assign alert_n = al_oe_n | al_o;
	initial forever #50 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #32 lk_clk = ~lk_clk;
	end
	pmc_ctrl #(.TICK_CYCLES(4)) u_pmc_ctrl (.ref_clk(ref_clk), .srst(srst),
		.lk_clk(lk_clk), .lk_srst(lk_srst), .lk_req_valid(req_v),
		.lk_req(req), .lk_ready(rdy), .lk_rsp_valid(rv), .lk_rsp_data(rsp),
		.alert_o(al_o), .alert_oe_n(al_oe_n), .plant(plant),
		.led_input(led_i), .led_output(led_o), .led_fault(led_f),
		.led_service(led_s), .stretch_en(str), .oring_test(orng),
		.cc_hold(cch), .ov_restart(ovr), .ov_latched(ovl));
	pmc_mst u_mst0 (.lk_clk(lk_clk), .req_valid(req_v[0]), .req(req[0]),
		.ready(rdy[0]), .rsp_valid(rv[0]), .rsp_data(rsp[0]));
	pmc_mst u_mst1 (.lk_clk(lk_clk), .req_valid(req_v[1]), .req(req[1]),
		.ready(rdy[1]), .rsp_valid(rv[1]), .rsp_data(rsp[1]));
	// ****
	// Tasks
	// ****
	function automatic pmc_frame_t fr(logic r, logic [7:0] c, logic [5:0] i,
		logic [7:0] d, logic l, logic p);
		fr = '{r, c, i, d, l, p};
	endfunction
	task automatic xf(input bit b, input pmc_frame_t f, output logic [7:0] d);
		if (b)
			u_mst1.xfer(f, d);
		else
			u_mst0.xfer(f, d);
	endtask
	// Byte write: data frame then the closing frame with its check result
	task automatic wr(input bit b, input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		xf(b, fr(1'b0, c, 6'h00, d, 1'b0, 1'b0), x);
		xf(b, fr(1'b0, c, 6'h00, 8'h00, 1'b1, 1'b1), x);
	endtask
	task automatic cmd(input bit b, input logic [7:0] c, input logic p);
		logic [7:0] x;
		xf(b, fr(1'b0, c, 6'h00, 8'h00, 1'b1, p), x);
		repeat (10) @(posedge ref_clk);
	endtask
	task automatic chk(input string s, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rc(input string s, input bit b, input logic [7:0] c,
		input logic [5:0] i, input logic [7:0] e);
		logic [7:0] d;
		xf(b, fr(1'b1, c, i, 8'h00, 1'b1, 1'b1), d);
		chk(s, {8'h00, e}, {8'h00, d});
	endtask
	task automatic tk(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****
	// Tests
	// ****
	initial begin
		#10_000_000;
		error_cnt++;
		final_report();
	end
	initial begin
		logic [7:0] x, c, i;
		int n;
		tk(10);
		srst <= 1'b0;
		lk_srst <= 1'b0;
		tk(3);
		chk("alert_idle", 16'h0003, {14'h0000, alert_n});
		rc("own_b0", 0, `PMC_CMD_BUS_STATUS, 0, 8'h01);
		rc("own_b1", 1, `PMC_CMD_BUS_STATUS, 0, 8'h01);
		wr(1, `PMC_CMD_TEST, 8'h01);
		tk(10);
		rc("cmd_err", 0, `PMC_CMD_BUS_STATUS, 0, 8'h81);
		rc("test_kept", 0, `PMC_CMD_TEST, 0, 8'h00);
		cmd(1, `PMC_CMD_CLEAR_FAULTS, 1'b1);
		rc("err_clr", 1, `PMC_CMD_BUS_STATUS, 0, 8'h01);
		cmd(1, `PMC_CMD_TAKEOVER, 1'b0);
		rc("bad_pec", 1, `PMC_CMD_BUS_STATUS, 0, 8'h81);
		cmd(1, `PMC_CMD_CLEAR_FAULTS, 1'b1);
		// Owner is mid-write, so the takeover must wait for its closing frame
		xf(0, fr(1'b0, `PMC_CMD_TEST, 6'h00, 8'h10, 1'b0, 1'b0), x);
		cmd(1, `PMC_CMD_TAKEOVER, 1'b1);
		rc("pending", 1, `PMC_CMD_BUS_STATUS, 0, 8'h21);
		chk("alert_wait", 16'h0003, {14'h0000, alert_n});
		xf(0, fr(1'b0, `PMC_CMD_TEST, 6'h00, 8'h00, 1'b1, 1'b1), x);
		tk(10);
		rc("moved", 0, `PMC_CMD_BUS_STATUS, 0, 8'h54);
		chk("alert_both", 16'h0000, {14'h0000, alert_n});
		chk("oring_kept", 16'h0001, {15'h0000, orng});
		cmd(0, `PMC_CMD_CLEAR_FAULTS, 1'b1);
		chk("alert_own", 16'h0001, {14'h0000, alert_n});
		cmd(1, `PMC_CMD_CLEAR_FAULTS, 1'b1);
		rc("own_new", 0, `PMC_CMD_BUS_STATUS, 0, 8'h10);
		for (n = 0; n < 2; n++) begin
			c = n ? `PMC_CMD_EE_HIGH : `PMC_CMD_EE_LOW;
			xf(1, fr(1'b0, c, 6'h00, 8'h20, 1'b0, 1'b0), x);
			for (i = 1; i <= 32; i++)
				xf(1, fr(1'b0, c, i[5:0], i ^ c, 1'b0, 1'b0), x);
			xf(1, fr(1'b0, c, 6'h21, 8'h00, 1'b1, 1'b1), x);
		end
		for (n = 0; n < 2; n++) begin
			c = n ? `PMC_CMD_EE_HIGH : `PMC_CMD_EE_LOW;
			rc("ee_count", 0, c, 0, 8'h20);
			for (i = 1; i <= 32; i++)
				rc("ee_byte", 0, c, i[5:0], i ^ c);
		end
		plant.fault <= 8'h04;
		tk(20);
		plant.fault <= 8'h00;
		tk(20);
		rc("transient", 0, `PMC_CMD_ALARM, 0, 8'h00);
		plant.settled <= 1'b1;
		plant.fault <= 8'h04;
		tk(20);
		chk("alarm_alert", 16'h0000, {14'h0000, alert_n});
		plant.fault <= 8'h00;
		tk(20);
		rc("frozen", 0, `PMC_CMD_ALARM, 0, 8'h04);
		cmd(0, `PMC_CMD_CLEAR_FAULTS, 1'b1);
		rc("non_owner", 0, `PMC_CMD_ALARM, 0, 8'h04);
		plant.fault <= 8'h04;
		cmd(1, `PMC_CMD_CLEAR_FAULTS, 1'b1);
		tk(10);
		rc("sticky", 1, `PMC_CMD_ALARM, 0, 8'h04);
		plant.fault <= 8'h00;
		// Three delayed retries inside one window, the fourth trip latches
		for (c = 0; c < 4; c++) begin
			tk(1);
			plant.ov_trip <= 1'b1;
			tk(3);
			plant.ov_trip <= 1'b0;
			for (n = 0; n < 5000 && ovr !== 1'b1 && c < 3; n++)
				@(posedge ref_clk);
			if (c < 3)
				chk("ov_delay", 16'h0001, {15'h0000, n > 3990 && n < 4010});
		end
		tk(10);
		chk("ov_latch", 16'h0001, {15'h0000, ovl});
		// Unit is kept off for 2 s before the restart action
		tk(8000);
		plant.restart_ok <= 1'b1;
		tk(3);
		plant.restart_ok <= 1'b0;
		tk(10);
		rc("restarted", 1, `PMC_CMD_STATE2, 0, 8'h01);
		rc("alarm_clr", 1, `PMC_CMD_ALARM, 0, 8'h00);
		wr(1, `PMC_CMD_TEST, 8'hFF);
		tk(10);
		rc("test_mask", 0, `PMC_CMD_TEST, 0, 8'h93);
		chk("leds_on", 16'h000F, {12'h000, led_i, led_o, led_f, led_s});
		chk("str_oring", 16'h0003, {14'h0000, str, orng});
		// Wait out the whole lit phase of the LED test
		for (n = 0; n < 30000 && led_o === 1'b1; n++)
			@(posedge ref_clk);
		chk("led_lit", 16'h0001, {15'h0000, n > 27900 && n < 28010});
		wr(1, `PMC_CMD_TEST, 8'h00);
		tk(10);
		chk("leds_off", 16'h0000, {12'h000, led_i, led_o, led_f, led_s});
		chk("str_off", 16'h0000, {14'h0000, str, orng});
		plant.pwr_up <= 1'b1;
		plant.overload <= 1'b1;
		plant.unit_on <= 1'b1;
		tk(10);
		chk("cc_hold", 16'h0001, {15'h0000, cch});
		chk("out_led", 16'h0001, {15'h0000, led_o});
		plant.overload <= 1'b0;
		plant.unit_on <= 1'b0;
		tk(10);
		chk("cc_off", 16'h0000, {14'h0000, cch, led_o});
		wr(1, `PMC_CMD_TEST, 8'h02);
		for (n = 0; n < 5000 && led_s !== 1'b0; n++)
			@(posedge ref_clk);
		for (n = 0; n < 5000 && led_s !== 1'b1; n++)
			@(posedge ref_clk);
		for (n = 0; n < 5000 && led_s === 1'b1; n++)
			@(posedge ref_clk);
		chk("flash_on", 16'd2000, n[15:0]);
		wr(1, `PMC_CMD_TEST, 8'h00);
		tk(10);
		chk("service_off", 16'h0000, {15'h0000, led_s});
		final_report();
	end
endmodule // test_dual_master_pmbus_control
